// ===== sapr_amp.sv
// Amplifier end: base circuit and ready sequencing, position reply
`timescale 1ns/1ps
`default_nettype none
`include "sapr_params.svh"
module sapr_amp #(
	parameter int unsigned SON_BASE_CYC = `SAPR_SON_BASE_CYC,
	parameter int unsigned ESTOP_BASE_CYC = `SAPR_ESTOP_BASE_CYC,
	parameter int unsigned BASE_READY_CYC = `SAPR_BASE_READY_CYC,
	parameter logic [7:0] STATION = 8'h00
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Link
	sapr_link_if.amp link,
	// Drive side
	input wire logic forced_stop,
	input wire logic alarm_in,
	input wire logic alarm_reset,
	input wire logic comm_fault,
	input wire sapr_pkg::sapr_pos_t current_pos,
	input wire logic absolute_detect_param,
	output logic base_on,
	output sapr_pkg::sapr_pos_t pos_command,
	output logic absolute_detect_enable
);
	import sapr_pkg::*;
	logic cfg_taken;
	logic estop_seen;
	logic alarm;
	wire son_done;
	wire estop_done;
	wire rdy_done;
	wire allowed = link.servo_on_request && !forced_stop && !alarm;
	wire long_done = estop_seen ? estop_done : son_done;
	wire addressed = link.req_valid && link.req_station == STATION;
	wire is_read = link.req_cmd == `SAPR_CMD_READ && link.req_data_no == `SAPR_DATA_ABS;
	// ----------------------------------------
	// Base circuit and ready timing
	// ----------------------------------------
	sapr_delay #(.CYCLES(SON_BASE_CYC)) u_son (.mclk(mclk), .rst(rst), .ce(ce),
		.start(allowed && !estop_seen), .done(son_done));
	sapr_delay #(.CYCLES(ESTOP_BASE_CYC)) u_estop (.mclk(mclk), .rst(rst), .ce(ce),
		.start(allowed && estop_seen), .done(estop_done));
	sapr_delay #(.CYCLES(BASE_READY_CYC)) u_rdy (.mclk(mclk), .rst(rst), .ce(ce),
		.start(base_on && allowed), .done(rdy_done));
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			base_on <= 1'b0;
			link.ready <= 1'b0;
			estop_seen <= 1'b0;
			alarm <= 1'b0;
			link.fault_trouble_out <= 1'b0;
		end else if (ce) begin
			base_on <= allowed && long_done;
			link.ready <= allowed && base_on && rdy_done;
			if (forced_stop)
				estop_seen <= 1'b1;
			else if (!link.servo_on_request)
				estop_seen <= 1'b0;
			if (alarm_in)
				alarm <= 1'b1;
			else if (alarm_reset)
				alarm <= 1'b0;
			link.fault_trouble_out <= alarm_in || (alarm && !alarm_reset);
		end
	end
	// ----------------------------------------
	// Position read reply
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			link.rsp_valid <= 1'b0;
			link.rsp_error <= 1'b0;
			link.rsp_code <= 8'h00;
			link.rsp_pos <= 32'h0;
			pos_command <= 32'h0;
		end else if (ce) begin
			link.rsp_valid <= addressed && is_read;
			if (addressed && is_read) begin
				if (comm_fault) begin
					link.rsp_error <= 1'b1;
					link.rsp_code <= `SAPR_ERR_COMM;
				end else begin
					link.rsp_error <= 1'b0;
					link.rsp_code <= 8'h00;
					link.rsp_pos <= current_pos;
					pos_command <= current_pos;
				end
			end
		end
	end
	// ----------------------------------------
	// Power-up setting latch
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cfg_taken <= 1'b0;
			absolute_detect_enable <= 1'b0;
		end else if (ce && !cfg_taken) begin
			cfg_taken <= 1'b1;
			absolute_detect_enable <= absolute_detect_param;
		end
	end
endmodule
`default_nettype wire

// ===== sapr_params.svh
// Constants for the serial absolute position readout
`ifndef SAPR_PARAMS_SVH
`define SAPR_PARAMS_SVH
`define SAPR_CMD_READ 8'h02
`define SAPR_DATA_ABS 8'h91
`define SAPR_CLK_KHZ 10000
`define SAPR_SON_BASE_MS 95
`define SAPR_ESTOP_BASE_MS 210
`define SAPR_BASE_READY_MS 5
`define SAPR_SON_BASE_CYC (`SAPR_SON_BASE_MS * `SAPR_CLK_KHZ)
`define SAPR_ESTOP_BASE_CYC (`SAPR_ESTOP_BASE_MS * `SAPR_CLK_KHZ)
`define SAPR_BASE_READY_CYC (`SAPR_BASE_READY_MS * `SAPR_CLK_KHZ)
`define SAPR_TIMEOUT_CYC 1000
`define SAPR_RETRY_LIMIT 3
`define SAPR_ERR_COMM 8'h01
`endif

// ===== sapr_pkg.sv
// Types for the serial absolute position readout
package sapr_pkg;
	typedef logic [31:0] sapr_pos_t;
	typedef logic [7:0] sapr_byte_t;
	typedef enum logic [1:0] {SAPR_IDLE, SAPR_WAIT, SAPR_DONE, SAPR_FAIL} sapr_host_e;
endpackage

// ===== sapr_link_if.sv
// Command link between controller and amplifier
`timescale 1ns/1ps
`default_nettype none
interface sapr_link_if;
	import sapr_pkg::*;
	logic req_valid;
	sapr_byte_t req_station;
	sapr_byte_t req_cmd;
	sapr_byte_t req_data_no;
	logic rsp_valid;
	logic rsp_error;
	sapr_byte_t rsp_code;
	sapr_pos_t rsp_pos;
	logic servo_on_request;
	logic ready;
	logic fault_trouble_out;
	modport ctrl (output req_valid, req_station, req_cmd, req_data_no, servo_on_request,
		input rsp_valid, rsp_error, rsp_code, rsp_pos, ready, fault_trouble_out);
	modport amp (input req_valid, req_station, req_cmd, req_data_no, servo_on_request,
		output rsp_valid, rsp_error, rsp_code, rsp_pos, ready, fault_trouble_out);
endinterface
`default_nettype wire

// ===== sapr_delay.sv
// Enable-gated delay counter, done level after a count of cycles
`timescale 1ns/1ps
`default_nettype none
module sapr_delay #(
	parameter int unsigned CYCLES = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Control
	input wire logic start,
	output logic done
);
	logic [31:0] cnt;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt <= 32'h0;
			done <= 1'b0;
		end else if (ce) begin
			if (!start) begin
				cnt <= 32'h0;
				done <= 1'b0;
			end else if (cnt >= CYCLES - 1) begin
				done <= 1'b1;
			end else begin
				cnt <= cnt + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== sapr_ctrl.sv
// Controller end: position acquisition with retries and time-out
`timescale 1ns/1ps
`default_nettype none
`include "sapr_params.svh"
module sapr_ctrl #(
	parameter int unsigned TIMEOUT_CYC = `SAPR_TIMEOUT_CYC,
	parameter logic [3:0] RETRY_LIMIT = 4'(`SAPR_RETRY_LIMIT)
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// Link
	sapr_link_if.ctrl link,
	// User side
	input wire logic servo_cmd,
	input wire sapr_pkg::sapr_byte_t station,
	output sapr_pkg::sapr_pos_t abs_pos,
	output logic pulses_allowed,
	output logic read_failed
);
	import sapr_pkg::*;
	sapr_host_e state;
	logic [31:0] timer;
	logic [3:0] tries;
	logic ready_d;
	wire ready_rise = link.ready && !ready_d;
	wire timed_out = timer >= TIMEOUT_CYC - 1;
	wire bad = timed_out || (link.rsp_valid && link.rsp_error);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= SAPR_IDLE;
			timer <= 32'h0;
			tries <= 4'h0;
			ready_d <= 1'b0;
			link.req_valid <= 1'b0;
			link.req_station <= 8'h00;
			link.req_cmd <= 8'h00;
			link.req_data_no <= 8'h00;
			link.servo_on_request <= 1'b0;
			abs_pos <= 32'h0;
			pulses_allowed <= 1'b0;
			read_failed <= 1'b0;
		end else if (ce) begin
			ready_d <= link.ready;
			link.servo_on_request <= servo_cmd && !link.fault_trouble_out;
			link.req_valid <= 1'b0;
			if (!link.ready) begin
				pulses_allowed <= 1'b0;
				state <= SAPR_IDLE;
			end else begin
				case (state)
				SAPR_IDLE: begin
					if (ready_rise) begin
						link.req_valid <= 1'b1;
						link.req_station <= station;
						link.req_cmd <= `SAPR_CMD_READ;
						link.req_data_no <= `SAPR_DATA_ABS;
						timer <= 32'h0;
						tries <= 4'h0;
						read_failed <= 1'b0;
						state <= SAPR_WAIT;
					end
				end
				SAPR_WAIT: begin
					timer <= timer + 32'h1;
					if (link.rsp_valid && !link.rsp_error) begin
						abs_pos <= link.rsp_pos;
						pulses_allowed <= 1'b1;
						state <= SAPR_DONE;
					end else if (bad) begin
						timer <= 32'h0;
						if (tries >= RETRY_LIMIT) begin
							read_failed <= 1'b1;
							state <= SAPR_FAIL;
						end else begin
							tries <= tries + 4'h1;
							link.req_valid <= 1'b1;
						end
					end
				end
				SAPR_DONE: begin
				end
				default: begin
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ===== sapr_link_checker.sv
// Checker on the link between controller and amplifier
`timescale 1ns/1ps
`default_nettype none
module sapr_link_checker (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Link
	input wire logic req_valid,
	input wire sapr_pkg::sapr_byte_t req_station,
	input wire sapr_pkg::sapr_byte_t req_cmd,
	input wire sapr_pkg::sapr_byte_t req_data_no,
	input wire logic rsp_valid,
	input wire logic rsp_error,
	input wire sapr_pkg::sapr_byte_t rsp_code,
	input wire logic servo_on_request,
	input wire logic ready,
	input wire logic fault_trouble_out
);
	import sapr_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence son_rise;
		$rose(servo_on_request);
	endsequence
	sequence base_wait;
		!ready [*8] ##1 !ready [*8] ##1 !ready [*8];
	endsequence
	chk_read_answer: assert property (req_valid && req_station == 8'h00 |=> rsp_valid)
		else $error("read request got no reply");
	chk_foreign_quiet: assert property (req_valid && req_station != 8'h00 |=> !rsp_valid)
		else $error("reply to another station's request");
	chk_cmd_code: assert property (req_valid |-> req_cmd == 8'h02 && req_data_no == 8'h91)
		else $error("read request has wrong codes");
	chk_err_code: assert property (rsp_valid && rsp_error |-> rsp_code == 8'h01)
		else $error("error reply has wrong code");
	chk_reply_pulse: assert property (rsp_valid |=> !rsp_valid)
		else $error("reply strobe longer than one cycle");
	chk_son_wait: assert property (son_rise |-> base_wait)
		else $error("ready too soon after servo-on");
	chk_ready_drop: assert property ($fell(servo_on_request) |-> ##[0:3] !ready)
		else $error("ready kept without servo-on");
	chk_req_on_ready: assert property ($rose(ready) |-> ##[1:2] req_valid)
		else $error("no read after ready rise");
	chk_alarm_son: assert property (fault_trouble_out |=> !servo_on_request)
		else $error("servo-on kept during alarm");
endmodule
`default_nettype wire

// ===== tb.sv
// Testbench joining controller and amplifier ends
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sapr_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	int replies = 0;
	logic servo_cmd = 1'b0;
	logic forced_stop = 1'b0;
	logic alarm_in = 1'b0;
	logic alarm_reset = 1'b0;
	logic comm_fault = 1'b0;
	logic absolute_detect_param = 1'b1;
	sapr_byte_t station = 8'h00;
	sapr_pos_t current_pos = 32'h1234abcd;
	logic base_on;
	logic pulses_allowed;
	logic read_failed;
	logic absolute_detect_enable;
	sapr_pos_t pos_command;
	sapr_pos_t abs_pos;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	int n;
	int m;
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_count++; $display("CHECK FAILED %s exp=%0h got=%0h", nm, ex, got); end end
	sapr_link_if link ();
	sapr_amp #(.SON_BASE_CYC(20), .ESTOP_BASE_CYC(40), .BASE_READY_CYC(5)) sapr_amp_i (.mclk(mclk), .rst(rst),
		.ce(ce), .link(link), .forced_stop(forced_stop), .alarm_in(alarm_in), .alarm_reset(alarm_reset),
		.comm_fault(comm_fault), .current_pos(current_pos), .absolute_detect_param(absolute_detect_param),
		.base_on(base_on), .pos_command(pos_command), .absolute_detect_enable(absolute_detect_enable));
	sapr_ctrl #(.TIMEOUT_CYC(10)) sapr_ctrl_i (.mclk(mclk), .rst(rst), .ce(ce), .link(link), .servo_cmd(servo_cmd),
		.station(station), .abs_pos(abs_pos), .pulses_allowed(pulses_allowed), .read_failed(read_failed));
	sapr_link_checker sapr_link_checker_i (.mclk(mclk), .rst(rst), .req_valid(link.req_valid),
		.req_station(link.req_station), .req_cmd(link.req_cmd), .req_data_no(link.req_data_no),
		.rsp_valid(link.rsp_valid), .rsp_error(link.rsp_error), .rsp_code(link.rsp_code),
		.servo_on_request(link.servo_on_request), .ready(link.ready), .fault_trouble_out(link.fault_trouble_out));
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic pick(input int s);
		case (s)
			0: pick = base_on;
			1: pick = link.ready;
			2: pick = pulses_allowed;
			default: pick = read_failed;
		endcase
	endfunction
	task automatic count_to(input int s, output int c);
		c = 0;
		while (pick(s) !== 1'b1 && c < 300) begin
			@(negedge mclk);
			c++;
		end
		if (c >= 300) begin
			err_count++;
			$display("CHECK FAILED wait_level exp=1 got=%0b", pick(s));
		end
	endtask
	always @(negedge mclk) begin
		if (link.rsp_valid === 1'b1)
			replies++;
	end
	task automatic summarize;
		$display("TB: checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		forever #50 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			summarize();
		end
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (20) @(negedge mclk);
		rst = 1'b0;
		servo_cmd = 1'b1;
		count_to(0, n);
		count_to(1, m);
		`CHK("son to base", 1'b1, n >= 20 && n <= 26)
		`CHK("base to ready", 1'b1, m >= 5 && m <= 8)
		count_to(2, n);
		`CHK("abs_pos", 32'h1234abcd, abs_pos)
		`CHK("pos_command", 32'h1234abcd, pos_command)
		`CHK("detect enable", 1'b1, absolute_detect_enable)
		$display("TB: power_up done");
		ce = 1'b0;
		servo_cmd = 1'b0;
		comm_fault = 1'b1;
		current_pos = 32'h00c0ffee;
		absolute_detect_param = 1'b0;
		repeat (5) @(negedge mclk);
		`CHK("frozen ready", 1'b1, link.ready)
		`CHK("frozen pulses", 1'b1, pulses_allowed)
		ce = 1'b1;
		repeat (5) @(negedge mclk);
		m = replies;
		servo_cmd = 1'b1;
		count_to(3, n);
		`CHK("fault retries", 4, replies - m)
		`CHK("fault read_failed", 1'b1, read_failed)
		`CHK("fault no pulses", 1'b0, pulses_allowed)
		`CHK("fault pos kept", 32'h1234abcd, pos_command)
		$display("TB: comm_fault done");
		comm_fault = 1'b0;
		station = 8'h05;
		servo_cmd = 1'b0;
		repeat (5) @(negedge mclk);
		servo_cmd = 1'b1;
		count_to(1, n);
		@(negedge mclk);
		`CHK("timeout cleared", 1'b0, read_failed)
		count_to(3, n);
		`CHK("timeout span", 1'b1, n >= 40 && n <= 42)
		`CHK("timeout read_failed", 1'b1, read_failed)
		`CHK("timeout pos kept", 32'h1234abcd, pos_command)
		$display("TB: timeout done");
		station = 8'h00;
		alarm_in = 1'b1;
		@(negedge mclk);
		alarm_in = 1'b0;
		repeat (3) @(negedge mclk);
		`CHK("alarm out", 1'b1, link.fault_trouble_out)
		`CHK("alarm ready", 1'b0, link.ready)
		alarm_reset = 1'b1;
		@(negedge mclk);
		alarm_reset = 1'b0;
		count_to(2, n);
		`CHK("reacquired", 32'h00c0ffee, abs_pos)
		$display("TB: alarm done");
		forced_stop = 1'b1;
		repeat (5) @(negedge mclk);
		`CHK("stop ready", 1'b0, link.ready)
		forced_stop = 1'b0;
		count_to(0, n);
		count_to(1, m);
		`CHK("stop to base", 1'b1, n >= 40 && n <= 46)
		`CHK("stop base to ready", 1'b1, m >= 5 && m <= 8)
		`CHK("detect held", 1'b1, absolute_detect_enable)
		$display("TB: forced_stop done");
		rst = 1'b1;
		current_pos = 32'h5a5a0f0f;
		repeat (3) @(negedge mclk);
		`CHK("reset ready", 1'b0, link.ready)
		`CHK("reset pulses", 1'b0, pulses_allowed)
		rst = 1'b0;
		repeat (2) @(negedge mclk);
		`CHK("detect relatched", 1'b0, absolute_detect_enable)
		count_to(2, n);
		`CHK("reset reacquired", 32'h5a5a0f0f, abs_pos)
		`CHK("reset pos_command", 32'h5a5a0f0f, pos_command)
		$display("TB: reset done");
		summarize();
	end
endmodule
`default_nettype wire
